// ===== common/tag_store_pkg.sv
// Shared constants and types for the tag word store and configuration decode
package tag_store_pkg;
   // ==========================================================
   // Store geometry
   localparam int WORD_W = 32;
   localparam int WORD_COUNT = 32;
   localparam int ADDR_W = 5;

   // ==========================================================
   // Word map
   localparam logic [4:0] ADDR_TAG_ID_LOW = 5'h00;
   localparam logic [4:0] ADDR_FAB_DATA = 5'h01;
   localparam logic [4:0] ADDR_OPTIONS = 5'h02;
   localparam logic [4:0] ADDR_WRITE_PROTECT = 5'h03;
   localparam logic [4:0] ADDR_READ_PROTECT = 5'h04;
   localparam logic [4:0] ADDR_FIRST_USER = 5'h05;

   // ==========================================================
   // Operating options word field positions
   localparam int FSC_MSB = 31;
   localparam int FSC_LSB = 28;
   localparam int FWT_MSB = 27;
   localparam int FWT_LSB = 24;
   localparam int TA1_MSB = 23;
   localparam int TA1_LSB = 17;
   localparam int BIT_NOT_LEVEL_FOUR = 16;
   localparam int BIT_P2P_TARGET = 15;
   localparam int BIT_POWERUP_IRQ = 14;
   localparam int BIT_ACTIVE_IRQ = 13;
   localparam int MODE_MSB = 12;
   localparam int MODE_LSB = 11;
   localparam int BIT_RX_NO_CRC = 10;
   localparam int BIT_RX_RAW = 9;
   localparam int BIT_TX_NO_CRC = 8;
   localparam int BIT_TX_RAW = 7;
   localparam int FDEL_MSB = 6;
   localparam int FDEL_LSB = 5;
   localparam int VREG_MSB = 4;
   localparam int VREG_LSB = 3;
   localparam int RREG_MSB = 2;
   localparam int RREG_LSB = 1;

   // Shipped default: frame size code 2h, waiting time code 6h
   localparam logic [31:0] OPTIONS_DEFAULT = 32'h26000000;

   // ==========================================================
   // Operating modes
   localparam logic [1:0] MODE_LEVEL4 = 2'h0;
   localparam logic [1:0] MODE_LEVEL3 = 2'h1;
   localparam logic [1:0] MODE_FRAMING = 2'h2;
   localparam logic [1:0] MODE_TRANSPARENT = 2'h3;

   // Frame delay trim codes and their carrier period counts
   localparam logic [1:0] FDEL_CODE_6 = 2'h0;
   localparam logic [1:0] FDEL_CODE_4 = 2'h1;
   localparam logic [1:0] FDEL_CODE_2 = 2'h2;
   localparam logic [3:0] FDEL_PERIODS_6 = 4'h6;
   localparam logic [3:0] FDEL_PERIODS_4 = 4'h4;
   localparam logic [3:0] FDEL_PERIODS_2 = 4'h2;
   localparam logic [3:0] FDEL_PERIODS_8 = 4'h8;

   // Regulator resistance code meaning disabled
   localparam logic [1:0] RREG_OFF = 2'h0;

   // ==========================================================
   // Access answer codes
   localparam logic [1:0] STAT_OK = 2'h0;
   localparam logic [1:0] STAT_LOCKED = 2'h1;
   localparam logic [1:0] STAT_FIELD_BUSY = 2'h2;

   // Controller states
   typedef enum logic [0:0] {ST_LOAD, ST_RUN} ctrl_state_t;
endpackage

// ===== rtl/tag_eeprom_config_mode_control.sv
// Tag word store with lock handling, options decode and transparent pin routing
`timescale 1ns/1ps
// Overview of operation
// - Level-3 mode: levels 2/3 as Level-4, all Level-4 blocks go to FIFO uninterpreted.
// - Active-entry option set: pulse interrupt on entering ACTIVE, in both protocol modes.
// - Level-3 and transparent modes allow SPI store access while RF field present.
// - Transparent, slave select high: MOSI drives modulator directly, high means on.
// - Transparent, slave select high: clock extractor to MISO, demodulator to IRQ.
// - Transparent, slave select low: SPI and IRQ pins return to normal function.
// - Store holds 32 words of 32 bits, words 0 to 31.
// - Words 0,1 read-only; 2 options; 3,4 one-time-programmable locks; 5-31 user data.
// - Writes to read-only words are refused, content unchanged.
// - Read-write words take writes until their write-protect bit is set.
// - Bits of one-time-programmable words never return to zero once set; reset here reloads words 3,4 as zero.
// - Word 0 supplies the four low bytes of the tag identifier.
// - Option bits 31:28 are the frame size code, default 2h.
// - Option bits 27:24 are the frame waiting time code, default 6h.
// - Option bits 23:17 form the TA(1) byte: same-rate, tag and reader divisors.
// - Bit 16 reports not Level-4 in SAK, bit 15 peer target; bit 16 prevails.
// - Bit 14 set: pulse interrupt when power-up initialization completes.
// - Bits 12:11 select Level-4, Level-3, framing or transparent mode.
// - Receive options bits 10,9 apply in Level-3, framing, and Level-4 FIFO frames.
// - Transmit options bits 8,7 apply under the same mode conditions.
// - Bits 6:5 trim reader-to-tag delay: 6, 4, 2 or 8 carrier periods.
// - Bits 4:3 regulator level, bits 2:1 enable and resistance, bit 0 reserved.
// - Lock word bit n protects store word n.
// - Read-protect bits for words 0 to 4 are ignored on the RF side.
module tag_eeprom_config_mode_control #(
   parameter logic [31:0] TAG_ID_LOW_INIT = 32'h01234567, // Arbitrary value
   parameter logic [31:0] FAB_DATA_INIT = 32'h0000a5a5 // Arbitrary value
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Reader-side word access
   input wire logic rf_req_i,
   input wire logic rf_we_i,
   input wire logic [tag_store_pkg::ADDR_W-1:0] rf_addr_i,
   input wire logic [tag_store_pkg::WORD_W-1:0] rf_wdata_i,
   output logic rf_ack_o,
   output logic [1:0] rf_status_o,
   output logic [tag_store_pkg::WORD_W-1:0] rf_rdata_o,
   // Controller-side word access
   input wire logic spi_req_i,
   input wire logic spi_we_i,
   input wire logic [tag_store_pkg::ADDR_W-1:0] spi_addr_i,
   input wire logic [tag_store_pkg::WORD_W-1:0] spi_wdata_i,
   output logic spi_ack_o,
   output logic [1:0] spi_status_o,
   output logic [tag_store_pkg::WORD_W-1:0] spi_rdata_o,
   // Protocol context
   input wire logic rf_field_i,
   input wire logic active_entry_i,
   input wire logic fifo_frame_i,
   // Pins and analog front end
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic miso_norm_i,
   input wire logic miso_norm_oe_i,
   input wire logic irq_norm_i,
   input wire logic clk_extract_i,
   input wire logic demod_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic irq_pin_o,
   output logic modulator_o,
   // Decoded configuration
   output logic init_done_o,
   output logic [31:0] tag_id_low_o,
   output logic [1:0] mode_o,
   output logic level4_passthrough_o,
   output logic [3:0] frame_size_code_o,
   output logic [3:0] frame_wait_code_o,
   output logic [7:0] ta1_byte_o,
   output logic sak_level4_o,
   output logic sak_p2p_target_o,
   output logic rx_skip_crc_o,
   output logic rx_raw_bits_o,
   output logic tx_skip_crc_o,
   output logic tx_raw_bits_o,
   output logic [3:0] delay_periods_o,
   output logic [1:0] vreg_sel_o,
   output logic [1:0] rreg_sel_o,
   output logic reg_enable_o,
   // Interrupt events
   output logic irq_powerup_o,
   output logic irq_active_entry_o
);
   import tag_store_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      ctrl_state_t st;
      logic [WORD_COUNT-1:0][WORD_W-1:0] mem;
      logic [31:0] cfg;
      logic rf_ack;
      logic [1:0] rf_status;
      logic [31:0] rf_rdata;
      logic spi_ack;
      logic [1:0] spi_status;
      logic [31:0] spi_rdata;
      logic miso;
      logic miso_oe;
      logic irq_pin;
      logic modulator;
      logic init_done;
      logic [31:0] tag_id;
      logic rx_skip_crc;
      logic rx_raw;
      logic tx_skip_crc;
      logic tx_raw;
      logic [3:0] delay_periods;
      logic powerup_irq_en;
      logic irq_act;
   } state_t;

   state_t r;
   state_t next_r;

   // ==========================================================
   // Helpers
   // Frame delay trim code to carrier periods
   function automatic logic [3:0] fdel_periods(input logic [1:0] code);
      case (code)
         FDEL_CODE_6: fdel_periods = FDEL_PERIODS_6;
         FDEL_CODE_4: fdel_periods = FDEL_PERIODS_4;
         FDEL_CODE_2: fdel_periods = FDEL_PERIODS_2;
         default: fdel_periods = FDEL_PERIODS_8;
      endcase
   endfunction

   // Write refused for fixed words or words whose protect bit is set
   function automatic logic write_refused(input logic [4:0] a, input logic [31:0] wlock);
      write_refused = (a == ADDR_TAG_ID_LOW) || (a == ADDR_FAB_DATA) || wlock[a];
   endfunction

   // Read protection only counts for user words, and only from the reader
   function automatic logic rf_read_hidden(input logic [4:0] a, input logic [31:0] rlock);
      rf_read_hidden = (a >= ADDR_FIRST_USER) && rlock[a];
   endfunction

   // Shipped store image
   function automatic logic [WORD_COUNT-1:0][WORD_W-1:0] factory_image();
      logic [WORD_COUNT-1:0][WORD_W-1:0] img;
      img = '0;
      img[ADDR_TAG_ID_LOW] = TAG_ID_LOW_INIT;
      img[ADDR_FAB_DATA] = FAB_DATA_INIT;
      img[ADDR_OPTIONS] = OPTIONS_DEFAULT;
      factory_image = img;
   endfunction

   // ==========================================================
   // Combinational working mode decode, shared by the next-state process
   logic [1:0] cur_mode;
   logic opts_apply;
   logic spi_allowed;
   logic bypass;

   // Working mode comes from the copy taken at init, not from the store
   assign cur_mode = r.cfg[MODE_MSB:MODE_LSB];
   assign opts_apply = (cur_mode == MODE_LEVEL3) || (cur_mode == MODE_FRAMING) ||
                       ((cur_mode == MODE_LEVEL4) && fifo_frame_i);
   assign spi_allowed = !rf_field_i || (cur_mode == MODE_LEVEL3) ||
                        (cur_mode == MODE_TRANSPARENT);
   assign bypass = (cur_mode == MODE_TRANSPARENT) && ss_n_i;

   // ==========================================================
   // Next state
   always_comb begin
      logic use_rf;
      logic acc_we;
      logic [4:0] acc_a;
      logic [31:0] acc_wd;
      logic [31:0] wlock;
      logic [31:0] rlock;
      logic [1:0] stat;
      logic [31:0] rd;
      use_rf = 1'b0;
      acc_we = 1'b0;
      acc_a = '0;
      acc_wd = '0;
      stat = STAT_OK;
      rd = '0;
      wlock = r.mem[ADDR_WRITE_PROTECT];
      rlock = r.mem[ADDR_READ_PROTECT];
      next_r = r;
      next_r.rf_ack = 1'b0;
      next_r.spi_ack = 1'b0;
      next_r.powerup_irq_en = 1'b0;
      next_r.irq_act = 1'b0;

      // Pin routing: bypass hands the front end straight to the SPI pins
      if (bypass) begin
         next_r.modulator = mosi_i;
         next_r.miso = clk_extract_i;
         next_r.miso_oe = 1'b1;
         next_r.irq_pin = demod_i;
      end else begin
         next_r.modulator = 1'b0;
         next_r.miso = miso_norm_i;
         next_r.miso_oe = miso_norm_oe_i;
         next_r.irq_pin = irq_norm_i;
      end

      // Option outputs; receive and transmit ones gated by the mode in which they have meaning, delay trim ungated
      next_r.rx_skip_crc = r.cfg[BIT_RX_NO_CRC] && opts_apply;
      next_r.rx_raw = r.cfg[BIT_RX_RAW] && opts_apply;
      next_r.tx_skip_crc = r.cfg[BIT_TX_NO_CRC] && opts_apply;
      next_r.tx_raw = r.cfg[BIT_TX_RAW] && opts_apply;
      next_r.delay_periods = fdel_periods(r.cfg[FDEL_MSB:FDEL_LSB]);

      case (r.st)
         ST_LOAD: begin
            // Requests wait here; nothing is answered until the copy is taken
            next_r.cfg = r.mem[ADDR_OPTIONS];
            next_r.tag_id = r.mem[ADDR_TAG_ID_LOW];
            next_r.init_done = 1'b1;
            next_r.powerup_irq_en = r.mem[ADDR_OPTIONS][BIT_POWERUP_IRQ];
            next_r.st = ST_RUN;
         end
         ST_RUN: begin
            // Active-entry event only counts in the two protocol modes
            next_r.irq_act = active_entry_i && r.cfg[BIT_ACTIVE_IRQ] &&
                             ((cur_mode == MODE_LEVEL4) || (cur_mode == MODE_LEVEL3));
            // One access per cycle; the reader wins, the controller is held off
            if (rf_req_i) begin
               use_rf = 1'b1;
               acc_we = rf_we_i;
               acc_a = rf_addr_i;
               acc_wd = rf_wdata_i;
            end else begin
               acc_we = spi_we_i;
               acc_a = spi_addr_i;
               acc_wd = spi_wdata_i;
            end
            if (rf_req_i || (spi_req_i && spi_allowed)) begin
               if (acc_we) begin
                  if (write_refused(acc_a, wlock)) begin
                     stat = STAT_LOCKED;
                  end else if ((acc_a == ADDR_WRITE_PROTECT) || (acc_a == ADDR_READ_PROTECT)) begin
                     next_r.mem[acc_a] = r.mem[acc_a] | acc_wd;
                  end else begin
                     next_r.mem[acc_a] = acc_wd;
                  end
               end else if (use_rf && rf_read_hidden(acc_a, rlock)) begin
                  rd = '0;
               end else begin
                  rd = r.mem[acc_a];
               end
            end else begin
               stat = STAT_FIELD_BUSY;
            end
            if (use_rf) begin
               next_r.rf_ack = 1'b1;
               next_r.rf_status = stat;
               next_r.rf_rdata = rd;
            end else if (spi_req_i) begin
               next_r.spi_ack = 1'b1;
               next_r.spi_status = stat;
               next_r.spi_rdata = rd;
            end
         end
         default: begin
            next_r.st = ST_LOAD;
         end
      endcase
   end

   // ==========================================================
   // State register; reset reloads the shipped image since the store is modelled in flops
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         r <= '0;
         r.st <= ST_LOAD;
         r.mem <= factory_image();
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs, all taken from state flops
   assign rf_ack_o = r.rf_ack;
   assign rf_status_o = r.rf_status;
   assign rf_rdata_o = r.rf_rdata;
   assign spi_ack_o = r.spi_ack;
   assign spi_status_o = r.spi_status;
   assign spi_rdata_o = r.spi_rdata;
   assign miso_o = r.miso;
   assign miso_oe_o = r.miso_oe;
   assign irq_pin_o = r.irq_pin;
   assign modulator_o = r.modulator;
   assign init_done_o = r.init_done;
   assign tag_id_low_o = r.tag_id;
   assign irq_powerup_o = r.powerup_irq_en;
   assign irq_active_entry_o = r.irq_act;
   assign rx_skip_crc_o = r.rx_skip_crc;
   assign rx_raw_bits_o = r.rx_raw;
   assign tx_skip_crc_o = r.tx_skip_crc;
   assign tx_raw_bits_o = r.tx_raw;
   assign delay_periods_o = r.delay_periods;

   // Field slices and simple decodes of the working copy
   assign mode_o = r.cfg[MODE_MSB:MODE_LSB];
   assign level4_passthrough_o = (r.cfg[MODE_MSB:MODE_LSB] == MODE_LEVEL3);
   assign frame_size_code_o = r.cfg[FSC_MSB:FSC_LSB];
   assign frame_wait_code_o = r.cfg[FWT_MSB:FWT_LSB];
   // TA(1): bit 7 same rate, 6:4 tag divisors 8,4,2, bit 3 zero, 2:0 reader divisors
   assign ta1_byte_o = {r.cfg[TA1_MSB:TA1_MSB-3], 1'b0, r.cfg[TA1_LSB+2:TA1_LSB]};
   // Not-Level-4 wins over the peer target flag
   assign sak_level4_o = !r.cfg[BIT_NOT_LEVEL_FOUR];
   assign sak_p2p_target_o = r.cfg[BIT_P2P_TARGET] && !r.cfg[BIT_NOT_LEVEL_FOUR];
   assign vreg_sel_o = r.cfg[VREG_MSB:VREG_LSB];
   assign rreg_sel_o = r.cfg[RREG_MSB:RREG_LSB];
   assign reg_enable_o = (r.cfg[RREG_MSB:RREG_LSB] != RREG_OFF);
endmodule

// ===== tb/tag_store_chk.sv
// Assertion checker for the tag word store, bound to its top module
`timescale 1ns/1ps
module tag_store_chk
   import tag_store_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Word access
   input wire logic rf_req_i, rf_we_i, spi_req_i, rf_ack_o, spi_ack_o, rf_field_i,
   input wire logic [4:0] rf_addr_i,
   input wire logic [1:0] rf_status_o, spi_status_o, mode_o,
   // Pins and events
   input wire logic ss_n_i, mosi_i, miso_norm_i, miso_norm_oe_i, irq_norm_i,
   input wire logic clk_extract_i, demod_i, miso_o, miso_oe_o, irq_pin_o, modulator_o,
   input wire logic active_entry_i, fifo_frame_i, init_done_o, level4_passthrough_o,
   input wire logic sak_level4_o, sak_p2p_target_o, rx_skip_crc_o,
   input wire logic irq_powerup_o, irq_active_entry_o
);
   // ==========================================================
   // Properties, all in the system clock domain
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   a_rf_ack_once: assert property (
      rf_ack_o == $past(rf_req_i && init_done_o)) else $error("rf ack mismatch");
   a_spi_ack_once: assert property (
      spi_ack_o == $past(spi_req_i && !rf_req_i && init_done_o)) else $error("spi ack mismatch");
   a_field_refuse: assert property (
      spi_req_i && !rf_req_i && init_done_o && rf_field_i &&
      (mode_o == MODE_LEVEL4 || mode_o == MODE_FRAMING) |=> spi_status_o == STAT_FIELD_BUSY)
      else $error("spi access with field not refused");
   a_ro_refuse: assert property (
      rf_req_i && rf_we_i && rf_addr_i < ADDR_OPTIONS && init_done_o
      |=> rf_status_o == STAT_LOCKED) else $error("read-only write not refused");
   a_init_load: assert property (
      $rose(rst_n_i) |=> init_done_o ##1 init_done_o) else $error("init not done in time");
   a_powerup_irq: assert property (
      irq_powerup_o |-> $rose(init_done_o)) else $error("power-up irq out of place");
   a_sak_order: assert property (
      sak_p2p_target_o |-> sak_level4_o) else $error("peer target without level four");
   a_l3_pass: assert property (
      level4_passthrough_o == (mode_o == MODE_LEVEL3)) else $error("passthrough mismatch");
   a_active_irq: assert property (
      irq_active_entry_o |-> $past(active_entry_i) && (mode_o == MODE_LEVEL4 ||
      mode_o == MODE_LEVEL3)) else $error("active irq out of place");
   a_rx_gate: assert property (
      rx_skip_crc_o |-> $past(mode_o) != MODE_TRANSPARENT &&
      ($past(mode_o) != MODE_LEVEL4 || $past(fifo_frame_i))) else $error("rx option ungated");
   a_pin_bypass: assert property (
      mode_o == MODE_TRANSPARENT && ss_n_i |=> modulator_o == $past(mosi_i) &&
      miso_o == $past(clk_extract_i) && irq_pin_o == $past(demod_i))
      else $error("bypass routing wrong");
   a_pin_normal: assert property (
      !(mode_o == MODE_TRANSPARENT && ss_n_i) |=> !modulator_o && miso_o == $past(miso_norm_i)
      && miso_oe_o == $past(miso_norm_oe_i) && irq_pin_o == $past(irq_norm_i))
      else $error("normal routing wrong");
endmodule

bind tag_eeprom_config_mode_control tag_store_chk chk (.*);

// ===== tb/tag_front_end_model.sv
// Front end and normal serial block model feeding the tag pins
`timescale 1ns/1ps
module tag_front_end_model (
   // Clock
   input wire logic clk_sys_i,
   // Front end and serial block outputs
   output logic clk_extract_o,
   output logic demod_o,
   output logic miso_norm_o,
   output logic miso_norm_oe_o,
   output logic irq_norm_o
);
   logic [3:0] cnt = 4'h0;

   // Pattern changes every cycle, so a stale or wrong route shows up
   always @(posedge clk_sys_i) cnt <= cnt + 4'h1;

   // Extractor and demodulator levels seen on the bypass path, then the normal serial block levels
   assign clk_extract_o = cnt[0];
   assign demod_o = cnt[1];
   assign miso_norm_o = cnt[2];
   assign miso_norm_oe_o = cnt[1] ^ cnt[3];
   assign irq_norm_o = cnt[3];
endmodule

// ===== tb/tag_eeprom_config_mode_control_test.sv
// Self-checking bench for the tag word store and options decode
`timescale 1ns/1ps
module tag_eeprom_config_mode_control_test;
   import tag_store_pkg::*;
   localparam logic [31:0] TID = 32'h5a3c0f11; // Arbitrary value
   localparam logic [31:0] FAB = 32'h00007e81; // Arbitrary value
   logic clk_sys_i, rst_n_i, rf_req_i, rf_we_i, spi_req_i, spi_we_i, rf_field_i, active_entry_i;
   logic fifo_frame_i, ss_n_i, mosi_i, miso_norm_i, miso_norm_oe_i, irq_norm_i, clk_extract_i;
   logic demod_i, rf_ack_o, spi_ack_o, miso_o, miso_oe_o, irq_pin_o, modulator_o, init_done_o;
   logic level4_passthrough_o, sak_level4_o, sak_p2p_target_o, rx_skip_crc_o, rx_raw_bits_o;
   logic tx_skip_crc_o, tx_raw_bits_o, reg_enable_o, irq_powerup_o, irq_active_entry_o;
   logic [4:0] rf_addr_i, spi_addr_i;
   logic [31:0] rf_wdata_i, spi_wdata_i, rf_rdata_o, spi_rdata_o, tag_id_low_o, exp;
   logic [1:0] rf_status_o, spi_status_o, mode_o, vreg_sel_o, rreg_sel_o;
   logic [3:0] frame_size_code_o, frame_wait_code_o, delay_periods_o;
   logic [7:0] ta1_byte_o;
   logic [4:0] ua [4] = '{5'h05, 5'h06, 5'h07, 5'h1f};
   int n_mismatch = 0;
   int checked = 0;

   // ==========================================================
   // Design, far side model and clock
   tag_eeprom_config_mode_control #(.TAG_ID_LOW_INIT(TID), .FAB_DATA_INIT(FAB)) dut (.*);
   tag_front_end_model fe (.clk_sys_i(clk_sys_i), .clk_extract_o(clk_extract_i),
      .demod_o(demod_i), .miso_norm_o(miso_norm_i), .miso_norm_oe_o(miso_norm_oe_i),
      .irq_norm_o(irq_norm_i));
   always #12.5 clk_sys_i = ~clk_sys_i;

   // ==========================================================
   // Compare, access and closing tasks
   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic chk_stat(input logic [2:0] got, input logic [2:0] want);
      checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("Error at %0t: ack/status %b want %b", $time, got, want);
      end
   endtask

   // One word access; a clock edge passes first so a request is never re-raised in one step
   task automatic acc(input logic s, input logic we, input logic [4:0] a, input logic [31:0] d,
         input logic [1:0] es, input logic [31:0] ed);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      #1;
      {rf_we_i, spi_we_i, rf_addr_i, spi_addr_i, rf_wdata_i, spi_wdata_i} = {we, we, a, a, d, d};
      if (s) spi_req_i = 1'b1;
      else rf_req_i = 1'b1;
      do begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while (!(s ? spi_ack_o : rf_ack_o) && n < 20);
      rf_req_i = 1'b0;
      spi_req_i = 1'b0;
      chk_stat(s ? {spi_ack_o, spi_status_o} : {rf_ack_o, rf_status_o}, {1'b1, es});
      if (es != STAT_FIELD_BUSY) chk_word(s ? spi_rdata_o : rf_rdata_o, ed);
   endtask

   task automatic stop_test;
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog: the tests need under a hundred cycles
   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end

   // ==========================================================
   // Test sequence
   initial begin
      {clk_sys_i, rst_n_i, rf_req_i, rf_we_i, spi_req_i, spi_we_i, rf_field_i} = 7'h00;
      {active_entry_i, fifo_frame_i, ss_n_i, mosi_i} = 4'h6;
      {rf_addr_i, spi_addr_i, rf_wdata_i, spi_wdata_i} = '0;
      repeat (10) @(posedge clk_sys_i);
      #1;
      rst_n_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk_word({frame_size_code_o, frame_wait_code_o, ta1_byte_o, mode_o, sak_level4_o,
         sak_p2p_target_o, delay_periods_o, reg_enable_o, irq_powerup_o, init_done_o},
         {4'h2, 4'h6, 8'h00, MODE_LEVEL4, 2'h2, FDEL_PERIODS_6, 3'h1});
      // Default options leave every gated option, regulator and passthrough off
      chk_word({rx_skip_crc_o, rx_raw_bits_o, tx_skip_crc_o, tx_raw_bits_o, vreg_sel_o,
         rreg_sel_o, level4_passthrough_o}, 32'h0);
      chk_word(tag_id_low_o, TID);
      acc(1'b0, 1'b0, ADDR_TAG_ID_LOW, 32'h0, STAT_OK, TID);
      acc(1'b0, 1'b0, ADDR_FAB_DATA, 32'h0, STAT_OK, FAB);
      acc(1'b0, 1'b0, ADDR_OPTIONS, 32'h0, STAT_OK, OPTIONS_DEFAULT);
      acc(1'b0, 1'b1, ADDR_TAG_ID_LOW, 32'hffffffff, STAT_LOCKED, 32'h0);
      acc(1'b1, 1'b1, ADDR_FAB_DATA, 32'h0, STAT_LOCKED, 32'h0);
      acc(1'b1, 1'b0, ADDR_TAG_ID_LOW, 32'h0, STAT_OK, TID);
      acc(1'b1, 1'b0, ADDR_FAB_DATA, 32'h0, STAT_OK, FAB);
      acc(1'b1, 1'b1, ADDR_OPTIONS, 32'h36001800, STAT_OK, 32'h0);
      acc(1'b0, 1'b0, ADDR_OPTIONS, 32'h0, STAT_OK, 32'h36001800);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 1'b1, ua[i], {ua[i], 27'h2d5a3c1}, STAT_OK, 32'h0);
         acc(1'b1, 1'b0, ua[i], 32'h0, STAT_OK, {ua[i], 27'h2d5a3c1});
      end
      // Protect word 6, then try it and its neighbour
      acc(1'b1, 1'b1, ADDR_WRITE_PROTECT, 32'h00000040, STAT_OK, 32'h0);
      acc(1'b0, 1'b1, 5'h06, 32'h0, STAT_LOCKED, 32'h0);
      acc(1'b0, 1'b0, 5'h06, 32'h0, STAT_OK, {5'h06, 27'h2d5a3c1});
      acc(1'b1, 1'b1, 5'h07, 32'h0000beef, STAT_OK, 32'h0);
      acc(1'b0, 1'b1, ADDR_WRITE_PROTECT, 32'h00000100, STAT_OK, 32'h0);
      acc(1'b0, 1'b0, ADDR_WRITE_PROTECT, 32'h0, STAT_OK, 32'h00000140);
      // Read protection of word 7 and of word 1, which must be ignored
      acc(1'b1, 1'b1, ADDR_READ_PROTECT, 32'h00000082, STAT_OK, 32'h0);
      acc(1'b0, 1'b0, 5'h07, 32'h0, STAT_OK, 32'h0);
      acc(1'b1, 1'b0, 5'h07, 32'h0, STAT_OK, 32'h0000beef);
      acc(1'b0, 1'b0, ADDR_FAB_DATA, 32'h0, STAT_OK, FAB);
      acc(1'b0, 1'b0, ADDR_READ_PROTECT, 32'h0, STAT_OK, 32'h00000082);
      // Field present in Level-4 mode: controller access refused, reader access served
      rf_field_i = 1'b1;
      acc(1'b1, 1'b1, ADDR_FIRST_USER, 32'h0, STAT_FIELD_BUSY, 32'h0);
      acc(1'b0, 1'b0, ADDR_FIRST_USER, 32'h0, STAT_OK, {5'h05, 27'h2d5a3c1});
      rf_field_i = 1'b0;
      // Both sides at once: reader first, controller one cycle later
      @(posedge clk_sys_i);
      #1;
      {rf_req_i, spi_req_i, rf_we_i, spi_we_i, spi_addr_i} = {4'hc, ADDR_FIRST_USER};
      @(posedge clk_sys_i);
      #1;
      chk_stat({rf_ack_o, spi_ack_o, 1'b0}, 3'h4);
      rf_req_i = 1'b0;
      @(posedge clk_sys_i);
      #1;
      spi_req_i = 1'b0;
      chk_stat({spi_ack_o, spi_status_o}, {1'b1, STAT_OK});
      chk_word(spi_rdata_o, {5'h05, 27'h2d5a3c1});
      // Pins keep their normal function outside transparent mode
      mosi_i = 1'b1;
      exp = {28'h0, 1'b0, miso_norm_i, miso_norm_oe_i, irq_norm_i};
      @(posedge clk_sys_i);
      #1;
      chk_word({modulator_o, miso_o, miso_oe_o, irq_pin_o}, exp);
      // Active entry with its option clear raises nothing
      active_entry_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      active_entry_i = 1'b0;
      chk_stat({2'h0, irq_active_entry_o}, 3'h0);
      stop_test;
   end
endmodule
